// File: common/rsds_map.svh
`ifndef RSDS_MAP_SVH
`define RSDS_MAP_SVH

// register byte offsets, then block codes matched against avs_address[7:4] and avs_address[7:6]
`define RSDS_CTRL        8'h00
`define RSDS_STATUS      8'h04
`define RSDS_TRIG_EN     8'h08
`define RSDS_TRIG_DELAY  8'h0C
`define RSDS_SCAN_LEN    8'h10
`define RSDS_OPEN_REQ    8'h14
`define RSDS_OPEN_DWELL  4'h2
`define RSDS_CLOSE_DWELL 4'h3
`define RSDS_MOD_ID      4'h4
`define RSDS_SEC_CFG     4'h5
`define RSDS_SCAN_BASE   2'h2

// field positions
`define RSDS_CTRL_ARM     0
`define RSDS_CTRL_DISARM  1
`define RSDS_CTRL_OPENALL 2
`define RSDS_CTRL_ONEMOD  3
`define RSDS_CTRL_MOD_LO  4
`define RSDS_CTRL_SRC_LO  8
`define RSDS_ENT_MOD_LO   8
`define RSDS_ENT_SEC_LO   12
`define RSDS_OREQ_CH_LO   8

// reset values
`define RSDS_DWELL_RST    16'h0000
`define RSDS_TRIG_EN_RST  8'h00
`define RSDS_SEC_CFG_RST  12'h000

// timing
`define RSDS_CLK_MHZ      200
`define RSDS_TICK_US      100
`define RSDS_PULSE_US     3
`define RSDS_ENC_WAIT_MS  5
`define RSDS_ENC_LOW_MS   4

`endif

// File: common/rsds_pkg.sv
package rsds_pkg;
  typedef enum logic [2:0] {
    RSDS_IDLE   = 3'b000,
    RSDS_TDLY   = 3'b001,
    RSDS_ODWELL = 3'b010,
    RSDS_CDWELL = 3'b011,
    RSDS_TPULSE = 3'b100,
    RSDS_EWAIT  = 3'b101,
    RSDS_ELOW   = 3'b110,
    RSDS_OREQ   = 3'b111
  } rsds_state_t;
  typedef logic [15:0] rsds_dwell_t;
endpackage : rsds_pkg

// File: common/rsds_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rsds_tmr_if;
  logic        start;
  logic        use_ticks;
  logic [19:0] count;
  logic        done;
  modport seq   (output start, output use_ticks, output count, input done);
  modport timer (input start, input use_ticks, input count, output done);
endinterface : rsds_tmr_if
`default_nettype wire

// File: design/rsds_timer.sv
`timescale 1ns/10ps
`default_nettype none
// one-shot down-counter; counts 100 us ticks or plain cycles
module rsds_timer #(
  parameter int TICK_CYC = 20000
) (
  input wire logic   clk,
  input wire logic   rstn,
  rsds_tmr_if.timer  t
);
  logic [19:0] remain;
  logic [14:0] pre;
  logic        run;
  logic        ticks;

  assign t.done = run && (remain == 20'h00000);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      run    <= 1'b0;
      ticks  <= 1'b0;
      remain <= 20'h00000;
      pre    <= 15'h0000;
    end
    else if (t.start)
    begin
      run    <= 1'b1;
      ticks  <= t.use_ticks;
      remain <= t.count;
      pre    <= 15'h0000;
    end
    else if (run)
    begin
      if (remain == 20'h00000)
        run <= 1'b0;
      else if (!ticks || pre == 15'(TICK_CYC - 1))
      begin
        remain <= remain - 20'h00001;
        pre    <= 15'h0000;
      end
      else
        pre <= pre + 15'h0001;
    end
  end
endmodule : rsds_timer
`default_nettype wire

// File: design/rsds_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsds_map.svh"

// How it works
// R1: wait module open dwell after opening
// R2: open dwell writes above 65535 rejected
// R3: reset clears every open dwell
// R4: open-all unselected opens every module
// R5: open-all with module opens that module
// R6: open-all leaves section configuration alone
// R7: reset opens every relay
// R8: armed trigger fall starts trigger delay
// R9: after delay open current scan relay
// R10: after open dwell close next relay
// R11: after close dwell pulse enabled lines 3us
// R12: wait 5ms, encode section low 4ms
// R13: each trigger output has own enable
// R14: reset clears trigger output enables
// R15: enables read back from register
// R16: section config write opens that module
// R17: default ids follow slot order, writable
// R18: multi-module open uses longest dwell once
// R19: triggers ignored until armed
// R20: first trigger closes first relay only
// R21: dwell timers 16-bit, 100us tick
module rsds_top #(
  parameter int TICK_CYC     = `RSDS_TICK_US * `RSDS_CLK_MHZ,
  parameter int ENC_WAIT_CYC = `RSDS_ENC_WAIT_MS * 1000 * `RSDS_CLK_MHZ,
  parameter int ENC_LOW_CYC  = `RSDS_ENC_LOW_MS * 1000 * `RSDS_CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  ttl_in,
  output logic      [7:0]  ttl_out,
  output logic      [7:0]  ttl_oe_n,
  output logic      [5:0]  encode_n,
  output logic      [255:0] relay_closed,
  output logic      [47:0] section_cfg
);
  localparam int PULSE_CYC = `RSDS_PULSE_US * `RSDS_CLK_MHZ;

  rsds_pkg::rsds_state_t state;
  rsds_pkg::rsds_state_t next_state;
  rsds_pkg::rsds_dwell_t open_dwell [4];
  rsds_pkg::rsds_dwell_t close_dwell [4];
  rsds_pkg::rsds_dwell_t trig_delay;
  logic [7:0]  mod_id [4];
  logic [15:0] scan_list [16];
  logic [4:0]  scan_len;
  logic [7:0]  trig_en;
  logic [2:0]  trig_src;
  logic        armed;
  logic        have_closed;
  logic [3:0]  cur_idx;
  logic [3:0]  nxt_idx;
  logic [2:0]  enc_sec;
  logic [7:0]  ttl_s1;
  logic [7:0]  ttl_s2;
  logic [7:0]  ttl_s3;
  logic        trig_fall;
  logic        req;
  logic        wr_fire;
  logic [31:0] wval;
  logic [31:0] rd_val;
  logic        oreq_go;
  logic        open_cur;
  logic        close_first;
  logic        close_next;
  logic [3:0]  ctl_mod;
  logic [1:0]  m;

  rsds_tmr_if tmr ();

  rsds_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .t    (tmr)
  );

  function automatic logic [31:0] rsds_be_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
    logic [31:0] msk;
    msk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~msk) | (new_v & msk);
  endfunction : rsds_be_merge

  function automatic rsds_pkg::rsds_dwell_t rsds_max_dwell(input logic [3:0] sel,
      input rsds_pkg::rsds_dwell_t d0, input rsds_pkg::rsds_dwell_t d1,
      input rsds_pkg::rsds_dwell_t d2, input rsds_pkg::rsds_dwell_t d3);
    rsds_pkg::rsds_dwell_t mx;
    mx = 16'h0000;
    if (sel[0] && d0 > mx) mx = d0;
    if (sel[1] && d1 > mx) mx = d1;
    if (sel[2] && d2 > mx) mx = d2;
    if (sel[3] && d3 > mx) mx = d3;
    return mx;
  endfunction : rsds_max_dwell

  // bus handshake: waitrequest drops one cycle after a request arrives
  assign req     = avs_read || avs_write;
  assign wr_fire = avs_write && !avs_waitrequest;
  assign m       = avs_address[3:2];
  assign nxt_idx = (cur_idx + 4'h1 >= scan_len[3:0] && scan_len != 5'h10) ? 4'h0
                   : cur_idx + 4'h1;
  assign ctl_mod = 4'h1 << avs_writedata[`RSDS_CTRL_MOD_LO +: 2];

  always_comb
  begin
    case (avs_address[7:4])
      `RSDS_OPEN_DWELL:  rd_val = {16'h0000, open_dwell[m]};
      `RSDS_CLOSE_DWELL: rd_val = {16'h0000, close_dwell[m]};
      `RSDS_MOD_ID:      rd_val = {24'h000000, mod_id[m]};
      `RSDS_SEC_CFG:     rd_val = {20'h00000, section_cfg[12*m +: 12]};
      default:           rd_val = 32'h00000000;
    endcase
    if (avs_address[7:6] == `RSDS_SCAN_BASE)
      rd_val = {16'h0000, scan_list[avs_address[5:2]]};
    case (avs_address)
      `RSDS_CTRL:       rd_val = {21'h000000, trig_src, 7'h00, armed};
      `RSDS_STATUS:     rd_val = {24'h000000, have_closed, cur_idx, state};
      `RSDS_TRIG_EN:    rd_val = {24'h000000, trig_en}; // [R15]
      `RSDS_TRIG_DELAY: rd_val = {16'h0000, trig_delay};
      `RSDS_SCAN_LEN:   rd_val = {27'h0000000, scan_len};
      default:          rd_val = rd_val;
    endcase
    wval = rsds_be_merge(rd_val, avs_writedata, avs_byteenable);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest)
        avs_readdata <= avs_read ? rd_val : 32'h00000000;
    end
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      trig_en    <= `RSDS_TRIG_EN_RST; // [R14]
      trig_delay <= `RSDS_DWELL_RST;
      trig_src   <= 3'h0;
      scan_len   <= 5'h00;
      for (int i = 0; i < 4; i++)
      begin
        open_dwell[i]  <= `RSDS_DWELL_RST; // [R3]
        close_dwell[i] <= `RSDS_DWELL_RST;
        mod_id[i]      <= 8'(i + 1); // [R17]
      end
    end
    else if (wr_fire)
    begin
      case (avs_address)
        `RSDS_CTRL:       trig_src <= wval[`RSDS_CTRL_SRC_LO +: 3];
        `RSDS_TRIG_EN:    trig_en <= wval[7:0]; // [R13]
        `RSDS_TRIG_DELAY: trig_delay <= wval[15:0];
        `RSDS_SCAN_LEN:   scan_len <= (wval[4:0] > 5'h10) ? 5'h10 : wval[4:0];
        default:          ;
      endcase
      case (avs_address[7:4])
        `RSDS_OPEN_DWELL:
          if (wval[31:16] == 16'h0000) // [R2]
            open_dwell[m] <= wval[15:0];
        `RSDS_CLOSE_DWELL: close_dwell[m] <= wval[15:0];
        `RSDS_MOD_ID:      mod_id[m] <= wval[7:0]; // [R17]
        default:           ;
      endcase
    end
  end

  // scan list memory
  always_ff @(posedge clk)
  begin
    if (wr_fire && avs_address[7:6] == `RSDS_SCAN_BASE)
      scan_list[avs_address[5:2]] <= wval[15:0];
  end

  // trigger inputs come from the backplane, so synchronise first
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ttl_s1 <= 8'hFF;
      ttl_s2 <= 8'hFF;
      ttl_s3 <= 8'hFF;
    end
    else
    begin
      ttl_s1 <= ttl_in;
      ttl_s2 <= ttl_s1;
      ttl_s3 <= ttl_s2;
    end
  end
  assign trig_fall = ttl_s3[trig_src] && !ttl_s2[trig_src];

  assign oreq_go     = wr_fire && avs_address == `RSDS_OPEN_REQ &&
                       state == rsds_pkg::RSDS_IDLE;
  assign open_cur    = state == rsds_pkg::RSDS_TDLY && tmr.done && have_closed; // [R9]
  assign close_first = state == rsds_pkg::RSDS_TDLY && tmr.done && !have_closed; // [R20]
  assign close_next  = state == rsds_pkg::RSDS_ODWELL && tmr.done; // [R10]

  // sequencer next state and timer loads
  always_comb
  begin
    next_state    = state;
    tmr.start     = 1'b0;
    tmr.use_ticks = 1'b1; // [R21]
    tmr.count     = 20'h00000;
    case (state)
      rsds_pkg::RSDS_IDLE:
        if (oreq_go)
        begin
          next_state = rsds_pkg::RSDS_OREQ;
          tmr.start  = 1'b1;
          tmr.count  = {4'h0, rsds_max_dwell(wval[3:0], open_dwell[0], open_dwell[1],
                                open_dwell[2], open_dwell[3])}; // [R18] [R1]
        end
        else if (armed && trig_fall && scan_len != 5'h00) // [R19]
        begin
          next_state = rsds_pkg::RSDS_TDLY; // [R8]
          tmr.start  = 1'b1;
          tmr.count  = {4'h0, trig_delay};
        end
      rsds_pkg::RSDS_TDLY:
        if (tmr.done)
        begin
          tmr.start = 1'b1;
          if (have_closed)
          begin
            next_state = rsds_pkg::RSDS_ODWELL;
            tmr.count  = {4'h0, open_dwell[scan_list[cur_idx][`RSDS_ENT_MOD_LO +: 2]]}; // [R1]
          end
          else
          begin
            next_state = rsds_pkg::RSDS_CDWELL;
            tmr.count  = {4'h0, close_dwell[scan_list[cur_idx][`RSDS_ENT_MOD_LO +: 2]]};
          end
        end
      rsds_pkg::RSDS_ODWELL:
        if (tmr.done)
        begin
          next_state = rsds_pkg::RSDS_CDWELL;
          tmr.start  = 1'b1;
          tmr.count  = {4'h0, close_dwell[scan_list[nxt_idx][`RSDS_ENT_MOD_LO +: 2]]};
        end
      rsds_pkg::RSDS_CDWELL:
        if (tmr.done)
        begin
          next_state    = rsds_pkg::RSDS_TPULSE; // [R11]
          tmr.start     = 1'b1;
          tmr.use_ticks = 1'b0;
          tmr.count     = 20'(PULSE_CYC - 1);
        end
      rsds_pkg::RSDS_TPULSE:
        if (tmr.done)
        begin
          next_state    = rsds_pkg::RSDS_EWAIT; // [R12]
          tmr.start     = 1'b1;
          tmr.use_ticks = 1'b0;
          tmr.count     = 20'(ENC_WAIT_CYC - 1);
        end
      rsds_pkg::RSDS_EWAIT:
        if (tmr.done)
        begin
          next_state    = rsds_pkg::RSDS_ELOW; // [R12]
          tmr.start     = 1'b1;
          tmr.use_ticks = 1'b0;
          tmr.count     = 20'(ENC_LOW_CYC - 1);
        end
      rsds_pkg::RSDS_ELOW:
        if (tmr.done)
          next_state = rsds_pkg::RSDS_IDLE;
      rsds_pkg::RSDS_OREQ:
        if (tmr.done)
          next_state = rsds_pkg::RSDS_IDLE;
      default:
        next_state = rsds_pkg::RSDS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state       <= rsds_pkg::RSDS_IDLE;
      armed       <= 1'b0;
      have_closed <= 1'b0;
      cur_idx     <= 4'h0;
      enc_sec     <= 3'h0;
    end
    else
    begin
      state <= next_state;
      if (wr_fire && avs_address == `RSDS_CTRL && wval[`RSDS_CTRL_DISARM])
        armed <= 1'b0;
      else if (wr_fire && avs_address == `RSDS_CTRL && wval[`RSDS_CTRL_ARM])
      begin
        armed       <= 1'b1; // [R19]
        have_closed <= 1'b0;
        cur_idx     <= 4'h0;
      end
      if (close_first)
      begin
        have_closed <= 1'b1;
        enc_sec     <= scan_list[cur_idx][`RSDS_ENT_SEC_LO +: 3];
      end
      if (close_next)
      begin
        cur_idx <= nxt_idx;
        enc_sec <= scan_list[nxt_idx][`RSDS_ENT_SEC_LO +: 3];
      end
    end
  end

  // relay and section state; one writer so priorities stay explicit
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      relay_closed <= 256'h0; // [R7]
      section_cfg  <= {4{`RSDS_SEC_CFG_RST}};
    end
    else
    begin
      if (wr_fire && avs_address[7:4] == `RSDS_SEC_CFG)
      begin
        section_cfg[12*m +: 12]  <= wval[11:0];
        relay_closed[64*m +: 64] <= 64'h0; // [R16]
      end
      else if (wr_fire && avs_address == `RSDS_CTRL && wval[`RSDS_CTRL_OPENALL])
      begin
        for (int i = 0; i < 4; i++)
          if (!wval[`RSDS_CTRL_ONEMOD] || ctl_mod[i]) // [R4] [R5]
            relay_closed[64*i +: 64] <= 64'h0; // section_cfg untouched [R6]
      end
      else if (oreq_go)
      begin
        for (int i = 0; i < 4; i++)
          if (wval[i])
            relay_closed[{2'(i), wval[`RSDS_OREQ_CH_LO +: 6]}] <= 1'b0;
      end
      if (open_cur)
        relay_closed[{scan_list[cur_idx][`RSDS_ENT_MOD_LO +: 2],
                      scan_list[cur_idx][5:0]}] <= 1'b0; // [R9]
      if (close_first)
        relay_closed[{scan_list[cur_idx][`RSDS_ENT_MOD_LO +: 2],
                      scan_list[cur_idx][5:0]}] <= 1'b1; // [R20]
      if (close_next)
        relay_closed[{scan_list[nxt_idx][`RSDS_ENT_MOD_LO +: 2],
                      scan_list[nxt_idx][5:0]}] <= 1'b1; // [R10]
    end
  end

  // open-collector trigger lines: output held low, enable does the pulsing
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_ttl
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          ttl_oe_n[g] <= 1'b1;
          ttl_out[g]  <= 1'b0;
        end
        else
        begin
          ttl_oe_n[g] <= !(next_state == rsds_pkg::RSDS_TPULSE && trig_en[g]); // [R11] [R13]
          ttl_out[g]  <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rstn)
      encode_n <= 6'h3F;
    else
      for (int i = 0; i < 6; i++)
        encode_n[i] <= !(next_state == rsds_pkg::RSDS_ELOW && enc_sec == 3'(i)); // [R12]
  end
endmodule : rsds_top
`default_nettype wire

// File: verification/rsds_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rsds_top_asserts #(
  parameter int ENC_WAIT_CYC = 1000000,
  parameter int ENC_LOW_CYC  = 800000
) (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic         avs_waitrequest,
  input wire logic [7:0]   ttl_out,
  input wire logic [7:0]   ttl_oe_n,
  input wire logic [5:0]   encode_n,
  input wire logic [255:0] relay_closed
);
  localparam int PULSE = 600;
  localparam int EW_LO = ENC_WAIT_CYC - 2;
  localparam int EW_HI = ENC_WAIT_CYC + 2;
  logic [19:0] oe_cnt;
  logic [19:0] enc_cnt;
  logic [19:0] gap_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // long spans are counted here, a repetition of that length would not unroll
  always_ff @(posedge clk)
    oe_cnt <= (!rstn || &ttl_oe_n) ? 20'h0 : oe_cnt + 20'h1;
  always_ff @(posedge clk)
    enc_cnt <= (!rstn || &encode_n) ? 20'h0 : enc_cnt + 20'h1;
  always_ff @(posedge clk)
    if (!rstn || !(&encode_n))
      gap_cnt <= 20'h0;
    else if (&ttl_oe_n && !(&$past(ttl_oe_n)))
      gap_cnt <= 20'h1;
    else if (gap_cnt != 20'h0)
      gap_cnt <= gap_cnt + 20'h1;
  sequence s_pulse_end;
    &ttl_oe_n && !(&$past(ttl_oe_n));
  endsequence
  sequence s_enc_start;
    !(&encode_n) && &$past(encode_n);
  endsequence
  sequence s_enc_end;
    &encode_n && !(&$past(encode_n));
  endsequence
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_rst_idle;
    $rose(rstn) |-> relay_closed == 256'h0 && ttl_oe_n == 8'hFF && encode_n == 6'h3F;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle at reset");
  property p_ttl_data;
    ttl_out == 8'h00;
  endproperty
  a_ttl_data: assert property (p_ttl_data) else $error("trigger data not low");
  property p_pulse_len;
    s_pulse_end |-> oe_cnt == PULSE;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("trigger pulse length");
  property p_pulse_steady;
    !(&ttl_oe_n) && !(&$past(ttl_oe_n)) |-> $stable(ttl_oe_n);
  endproperty
  a_pulse_steady: assert property (p_pulse_steady) else $error("pulse lines moved");
  property p_enc_len;
    s_enc_end |-> enc_cnt == ENC_LOW_CYC;
  endproperty
  a_enc_len: assert property (p_enc_len) else $error("encode low length");
  property p_enc_wait;
    s_enc_start |-> gap_cnt >= EW_LO && gap_cnt <= EW_HI;
  endproperty
  a_enc_wait: assert property (p_enc_wait) else $error("encode wait length");
  property p_enc_one;
    !(&encode_n) |-> $countones(~encode_n) == 1;
  endproperty
  a_enc_one: assert property (p_enc_one) else $error("more than one section");
  property p_relay_hold;
    !(&encode_n) && !(avs_write && !avs_waitrequest) |=> $stable(relay_closed);
  endproperty
  a_relay_hold: assert property (p_relay_hold) else $error("relay moved in encode");
endmodule : rsds_top_asserts
bind rsds_top rsds_top_asserts #(
  .ENC_WAIT_CYC (ENC_WAIT_CYC),
  .ENC_LOW_CYC  (ENC_LOW_CYC)
) i_chk (
  .clk             (clk),
  .rstn            (rstn),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_waitrequest (avs_waitrequest),
  .ttl_out         (ttl_out),
  .ttl_oe_n        (ttl_oe_n),
  .encode_n        (encode_n),
  .relay_closed    (relay_closed)
);
`default_nettype wire

// File: verification/rsds_trig_lines.sv
`timescale 1ns/10ps
`default_nettype none
// backplane lines: pulled up, low while any party drives them
module rsds_trig_lines (
  input wire logic [7:0] pull,
  input wire logic [7:0] ttl_out,
  input wire logic [7:0] ttl_oe_n,
  output logic     [7:0] ttl_in
);
  assign ttl_in = ~(pull | (~ttl_oe_n & ~ttl_out));
endmodule : rsds_trig_lines
`default_nettype wire

// File: verification/rsds_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rsds_top_bench;
  localparam int TK = 4;
  localparam logic [7:0]  CA [9] = '{8'h24, 8'h28, 8'h34, 8'h38, 8'h0C, 8'h10, 8'h80,
                                     8'h84, 8'h5C};
  localparam logic [31:0] CD [9] = '{32'h3, 32'h6, 32'h1, 32'h1, 32'h2, 32'h2, 32'h2103,
                                     32'h4205, 32'h123};
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic [7:0]   avs_address = 8'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [7:0]   pull = 8'h00;
  logic [7:0]   ttl_in;
  logic [7:0]   ttl_out;
  logic [7:0]   ttl_oe_n;
  logic [5:0]   encode_n;
  logic [255:0] relay_closed;
  logic [47:0]  section_cfg;
  logic [31:0]  rd;
  int           miscompares = 0;
  int           compares = 0;
  int           cyc = 0;
  rsds_top #(.TICK_CYC(TK), .ENC_WAIT_CYC(50), .ENC_LOW_CYC(40)) i_dut (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ttl_in(ttl_in),
    .ttl_out(ttl_out), .ttl_oe_n(ttl_oe_n), .encode_n(encode_n),
    .relay_closed(relay_closed), .section_cfg(section_cfg));
  rsds_trig_lines i_lines (.pull(pull), .ttl_out(ttl_out), .ttl_oe_n(ttl_oe_n),
    .ttl_in(ttl_in));
  always #2.5 clk = ~clk;
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk
  // request held until waitrequest is sampled low, taken at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 100) chk(32'h0, 32'h1, "bus hang");
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, w);
  endtask : rdc
  function automatic logic hit(input int sel, input int n);
    case (sel)
      0: return relay_closed[n] === 1'b0;
      1: return relay_closed[n] === 1'b1;
      2: return ttl_oe_n !== 8'hFF;
      3: return encode_n !== 6'h3F;
      default: return encode_n === 6'h3F;
    endcase
  endfunction : hit
  task automatic wait_on(input int sel, input int n, output int c);
    c = 0;
    while (!hit(sel, n) && c < 3000)
    begin
      @(posedge clk);
      c++;
    end
  endtask : wait_on
  task automatic trig;
    @(posedge clk);
    pull[1] <= 1'b1;
    @(posedge clk);
    pull[1] <= 1'b0;
  endtask : trig
  // one trigger and the whole sequence behind it
  task automatic step(input int oldb, input int newb, input int sec, input int dw);
    int n;
    int m;
    trig();
    if (oldb >= 0)
    begin
      wait_on(0, oldb, n);
      chk(n >= 2 * TK, 1, "delay before open");
      wait_on(1, newb, m);
      chk(m >= dw * TK && m <= dw * TK + 4, 1, "open dwell");
    end
    else
    begin
      wait_on(1, newb, n);
      chk(n >= 2 * TK, 1, "delay before close");
    end
    chk(relay_closed === (256'h1 << newb), 1, "one relay closed");
    wait_on(2, 0, n);
    chk(ttl_oe_n, 8'h5A, "trigger lines");
    wait_on(3, 0, n);
    chk(encode_n === ~(6'h01 << sec), 1, "encode section");
    wait_on(4, 0, n);
  endtask : step
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(relay_closed === 256'h0 && section_cfg === 48'h0, 1, "reset relays");
    for (int i = 0; i < 4; i++)
    begin
      rdc(8'h20 + 8'(4 * i), 32'h0, "open dwell reset");
      rdc(8'h40 + 8'(4 * i), 32'(i + 1), "default id");
    end
    rdc(8'h08, 32'h0, "enables reset");
    $display("test reset done");
    rdc(8'hFC, 32'h0, "unmapped read");
    wr(8'h40, 32'h5A);
    rdc(8'h40, 32'h5A, "id replaced");
    wr(8'h20, 32'h0001_0000);
    rdc(8'h20, 32'h0, "dwell over range");
    wr(8'h20, 32'hFFFF);
    rdc(8'h20, 32'hFFFF, "dwell at max");
    wr(8'h08, 32'hA5);
    rdc(8'h08, 32'hA5, "enables read back");
    $display("test registers done");
    for (int i = 0; i < 9; i++) wr(CA[i], CD[i]);
    trig();
    repeat (40) @(posedge clk);
    chk(relay_closed === 256'h0, 1, "trigger while disarmed");
    wr(8'h00, 32'h101);
    step(-1, 67, 2, 0);
    step(67, 133, 4, 3);
    step(133, 67, 2, 6);
    $display("test scan done");
    // a write lands at the edge that ends the task, so let it settle
    wr(8'h00, 32'h12C);
    @(posedge clk);
    chk(relay_closed === (256'h1 << 67), 1, "open-all other module");
    wr(8'h54, 32'h0AB);
    @(posedge clk);
    chk(relay_closed === 256'h0 && section_cfg[23:12] === 12'h0AB, 1, "config opens");
    step(-1, 133, 4, 0);
    wr(8'h00, 32'h104);
    @(posedge clk);
    chk(relay_closed === 256'h0, 1, "open-all every module");
    chk(section_cfg === 48'h123_000_0AB_000, 1, "config kept");
    $display("test open-all done");
    wr(8'h14, 32'h0506);
    repeat (14) @(posedge clk);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd[2:0], 32'h7, "still in longest dwell");
    repeat (10) @(posedge clk);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd[2:0], 32'h0, "dwell applied once");
    $display("test open request done");
    end_sim();
  end
endmodule : rsds_top_bench
`default_nettype wire
